// [clkpwr_pkg.sv]
// Constants, types and field layout for the clock source, PLL and power control block
package clkpwr_pkg;
	// ****************************************************************
	// Register map (byte offsets)
	// ****************************************************************
	localparam logic [7:0] OFS_CLK_SRC = 8'h00;
	localparam logic [7:0] OFS_PLL_CTRL = 8'h04;
	localparam logic [7:0] OFS_PLL_CFG = 8'h08;
	localparam logic [7:0] OFS_PLL_STAT = 8'h0c;
	localparam logic [7:0] OFS_CPU_DIV = 8'h10;
	localparam logic [7:0] OFS_USB_DIV = 8'h14;
	localparam logic [7:0] OFS_PCLK_GATE = 8'h18;
	localparam logic [7:0] OFS_PCLK_SEL = 8'h1c;
	localparam logic [7:0] OFS_PWR_MODE = 8'h20;
	localparam logic [7:0] OFS_WDOG_SEL = 8'h24;
	localparam logic [7:0] OFS_OSC_CTL = 8'h28;
	// ****************************************************************
	// Fields, encodings and reset values
	// ****************************************************************
	localparam int NUM_PERIPH = 8;
	localparam int PLL_EN_BIT = 0;
	localparam int PLL_CONN_BIT = 1;
	localparam int PLL_LOCK_BIT = 2;
	localparam int STAT_SRC_LSB = 4;
	localparam int CFG_MULT_LSB = 8;
	localparam int OSC_EN_BIT = 0;
	localparam int OSC_STABLE_BIT = 1;
	localparam logic [1:0] SRC_RC = 2'h0;
	localparam logic [1:0] SRC_MAIN = 2'h1;
	localparam logic [1:0] SRC_RTC = 2'h2;
	localparam logic [1:0] WDSRC_RC = 2'h0;
	localparam logic [1:0] WDSRC_RTC = 2'h1;
	localparam logic [2:0] MODE_IDLE = 3'h1;
	localparam logic [2:0] MODE_SLEEP = 3'h2;
	localparam logic [2:0] MODE_PDOWN = 3'h3;
	localparam logic [2:0] MODE_DPDOWN = 3'h4;
	localparam logic [NUM_PERIPH-1:0] PCLK_GATE_RST = 8'hff;
	// ****************************************************************
	// Timing, counted in oscillator cycles
	// ****************************************************************
	localparam int RC_FREQ_MHZ = 4;
	localparam int FLASH_WAKE_US = 100;
	localparam logic [8:0] FLASH_WAKE_TICKS = 9'(FLASH_WAKE_US * RC_FREQ_MHZ);
	localparam logic [12:0] WAKE_RC_TICKS = 13'h0004;
	localparam logic [12:0] WAKE_MAIN_TICKS = 13'h1000;
	localparam logic [12:0] OSC_STABLE_TICKS = 13'h1000;
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum {st_run, st_idle, st_sleep, st_pdown, st_dpdown, st_wake} pm_state_t;
	typedef struct packed {
		logic [14:0] mult_m1; // Multiplier minus one, 1..32768
		logic [7:0] prediv_m1; // Pre-divider minus one, 1..256
	} pll_cfg_t;
endpackage

// [clock_source_pll_control.sv]
// Clock source selection, PLL control, clock dividers and power modes
`timescale 1ns/1ps
`default_nettype none
module clock_source_pll_control (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic wb_ack_out,
	output logic [31:0] wb_dat_out,
	input wire logic rc_osc_in,
	input wire logic main_osc_in,
	input wire logic rtc_osc_in,
	input wire logic current_controlled_osc_in,
	input wire logic pll_lock_in,
	input wire logic wake_in,
	output logic cpu_core_clock_en_out,
	output logic usb_clk_en_out,
	output logic [clkpwr_pkg::NUM_PERIPH-1:0] pclk_en_out,
	output logic watchdog_tick_clock_en_out,
	output clkpwr_pkg::pll_cfg_t pll_cfg_out,
	output logic pll_enable_out,
	output logic main_osc_en_out,
	output logic rc_osc_en_out,
	output logic flash_pwr_out,
	output logic flash_ready_out,
	output logic cpu_run_out
);
	localparam int NP = clkpwr_pkg::NUM_PERIPH;

	// Byte-lane merge for Wishbone writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
			input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		merge = (old & ~m) | (dat & m);
	endfunction

	// Divide-by-1/2/4/8 mask from a two-bit select
	function automatic logic [2:0] div_mask(input logic [1:0] sel);
		div_mask = 3'((4'h1 << sel) - 4'h1);
	endfunction

	// ****************************************************************
	// Input synchronisers and edge detect
	// ****************************************************************
	logic [5:0] sync1_ff, sync2_ff, sync3_ff;
	logic [5:0] rise;
	logic rc_tick, main_tick, rtc_tick, cco_tick, lock_s, wake_evt;

	// Oscillators arrive from foreign domains; stage one feeds only stage two
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
			sync3_ff <= 6'h00;
		end else if (ce_in) begin
			sync1_ff <= {wake_in, pll_lock_in, current_controlled_osc_in, rtc_osc_in,
				main_osc_in, rc_osc_in};
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end
	assign rise = sync2_ff & ~sync3_ff;
	assign rc_tick = rise[0];
	assign main_tick = rise[1];
	assign rtc_tick = rise[2];
	assign cco_tick = rise[3];
	assign lock_s = sync2_ff[4];
	assign wake_evt = rise[5];

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic req, wr;
	logic [1:0] src_sel_ff, act_src_ff, wd_sel_ff;
	logic pll_en_ff, pll_conn_ff, pll_conn_act_ff, osc_en_ff, osc_stable_ff;
	clkpwr_pkg::pll_cfg_t pll_cfg_ff;
	logic [7:0] cpu_div_ff;
	logic [3:0] usb_div_ff;
	logic [NP-1:0] pconp_ff;
	logic [2*NP-1:0] pclksel_ff;
	clkpwr_pkg::pm_state_t pm_state_ff;
	logic [2:0] mode_code;

	assign req = wb_cyc_in & wb_stb_in;
	assign wr = req & wb_we_in & ack_ff; // Write lands on the edge that sees ack

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ack_ff <= 1'b0;
		end else if (ce_in) begin
			ack_ff <= req & ~ack_ff;
		end
	end

	always_comb begin
		case (pm_state_ff)
			clkpwr_pkg::st_idle: mode_code = clkpwr_pkg::MODE_IDLE;
			clkpwr_pkg::st_sleep: mode_code = clkpwr_pkg::MODE_SLEEP;
			clkpwr_pkg::st_pdown: mode_code = clkpwr_pkg::MODE_PDOWN;
			clkpwr_pkg::st_dpdown: mode_code = clkpwr_pkg::MODE_DPDOWN;
			default: mode_code = 3'h0;
		endcase
	end

	// Read data captured with the ack; unmapped offsets read zero
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdat_ff <= 32'h0000_0000;
		end else if (ce_in && req && !ack_ff) begin
			case (wb_adr_in)
				clkpwr_pkg::OFS_CLK_SRC: rdat_ff <= {30'h0, src_sel_ff};
				clkpwr_pkg::OFS_PLL_CTRL: rdat_ff <= {30'h0, pll_conn_ff, pll_en_ff};
				clkpwr_pkg::OFS_PLL_CFG: rdat_ff <= {9'h0, pll_cfg_ff};
				clkpwr_pkg::OFS_PLL_STAT: rdat_ff <= {26'h0, act_src_ff, 1'b0, lock_s,
					pll_conn_act_ff, pll_enable_out};
				clkpwr_pkg::OFS_CPU_DIV: rdat_ff <= {24'h0, cpu_div_ff};
				clkpwr_pkg::OFS_USB_DIV: rdat_ff <= {28'h0, usb_div_ff};
				clkpwr_pkg::OFS_PCLK_GATE: rdat_ff <= {24'h0, pconp_ff};
				clkpwr_pkg::OFS_PCLK_SEL: rdat_ff <= {16'h0, pclksel_ff};
				clkpwr_pkg::OFS_PWR_MODE: rdat_ff <= {29'h0, mode_code};
				clkpwr_pkg::OFS_WDOG_SEL: rdat_ff <= {30'h0, wd_sel_ff};
				clkpwr_pkg::OFS_OSC_CTL: rdat_ff <= {30'h0, osc_stable_ff, osc_en_ff};
				default: rdat_ff <= 32'h0000_0000;
			endcase
		end
	end
	assign wb_ack_out = ack_ff;
	assign wb_dat_out = rdat_ff;

	// ****************************************************************
	// Configuration registers and forced defaults
	// ****************************************************************
	logic enter_sleep, enter_pd, dpd_wake;
	logic [31:0] wv;
	assign wv = wb_dat_in;
	assign enter_sleep = (pm_state_ff == clkpwr_pkg::st_run) && wr &&
		(wb_adr_in == clkpwr_pkg::OFS_PWR_MODE) && (wv[2:0] >= clkpwr_pkg::MODE_SLEEP) &&
		(wv[2:0] <= clkpwr_pkg::MODE_DPDOWN) && wb_sel_in[0];
	assign enter_pd = enter_sleep && (wv[2:0] != clkpwr_pkg::MODE_SLEEP);
	assign dpd_wake = (pm_state_ff == clkpwr_pkg::st_dpdown) && wake_evt;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			src_sel_ff <= clkpwr_pkg::SRC_RC;
			pll_en_ff <= 1'b0;
			pll_conn_ff <= 1'b0;
			pll_cfg_ff <= '0;
			cpu_div_ff <= 8'h00;
			usb_div_ff <= 4'h0;
			pconp_ff <= clkpwr_pkg::PCLK_GATE_RST;
			pclksel_ff <= 16'h0000;
			wd_sel_ff <= clkpwr_pkg::WDSRC_RC;
			osc_en_ff <= 1'b0;
		end else if (ce_in) begin
			if (wr) begin
				case (wb_adr_in)
					clkpwr_pkg::OFS_CLK_SRC: begin
						// Code 3 names no oscillator, so the old choice stays
						if (wb_sel_in[0] && wv[1:0] != 2'h3) begin
							src_sel_ff <= wv[1:0];
						end
					end
					clkpwr_pkg::OFS_PLL_CTRL: begin
						if (wb_sel_in[0]) begin
							pll_en_ff <= wv[clkpwr_pkg::PLL_EN_BIT];
							pll_conn_ff <= wv[clkpwr_pkg::PLL_CONN_BIT];
						end
					end
					clkpwr_pkg::OFS_PLL_CFG: begin
						pll_cfg_ff <= 23'(merge({9'h0, pll_cfg_ff}, wv, wb_sel_in));
					end
					clkpwr_pkg::OFS_CPU_DIV: cpu_div_ff <= 8'(merge({24'h0, cpu_div_ff}, wv, wb_sel_in));
					clkpwr_pkg::OFS_USB_DIV: usb_div_ff <= 4'(merge({28'h0, usb_div_ff}, wv, wb_sel_in));
					clkpwr_pkg::OFS_PCLK_GATE: pconp_ff <= 8'(merge({24'h0, pconp_ff}, wv, wb_sel_in));
					clkpwr_pkg::OFS_PCLK_SEL: pclksel_ff <= 16'(merge({16'h0, pclksel_ff}, wv, wb_sel_in));
					clkpwr_pkg::OFS_WDOG_SEL: begin
						if (wb_sel_in[0]) begin
							wd_sel_ff <= wv[1:0];
						end
					end
					clkpwr_pkg::OFS_OSC_CTL: begin
						if (wb_sel_in[0]) begin
							osc_en_ff <= wv[clkpwr_pkg::OSC_EN_BIT];
						end
					end
					default: begin
					end
				endcase
			end
			// Sleep and deeper: PLL dropped and dividers cleared
			if (enter_sleep) begin
				pll_en_ff <= 1'b0;
				pll_conn_ff <= 1'b0;
				cpu_div_ff <= 8'h00;
				usb_div_ff <= 4'h0;
			end
			// Power-down also stops the crystal and returns to the RC source
			if (enter_pd) begin
				pll_en_ff <= 1'b0;
				osc_en_ff <= 1'b0;
				src_sel_ff <= clkpwr_pkg::SRC_RC;
			end
			// Deep power-down keeps no state: wake is a fresh start
			if (dpd_wake) begin
				pll_cfg_ff <= '0;
				pconp_ff <= clkpwr_pkg::PCLK_GATE_RST;
				pclksel_ff <= 16'h0000;
				wd_sel_ff <= clkpwr_pkg::WDSRC_RC;
			end
		end
	end

	// ****************************************************************
	// Power mode state machine and wake-up timers
	// ****************************************************************
	logic [12:0] wake_cnt_ff, wake_lim_ff, osc_cnt_ff;
	logic [8:0] flash_cnt_ff;
	logic flash_rdy_ff, ref_tick;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pm_state_ff <= clkpwr_pkg::st_run;
			wake_cnt_ff <= 13'h0000;
			wake_lim_ff <= clkpwr_pkg::WAKE_RC_TICKS;
		end else if (ce_in) begin
			case (pm_state_ff)
				clkpwr_pkg::st_run: begin
					if (wr && wb_adr_in == clkpwr_pkg::OFS_PWR_MODE && wb_sel_in[0]) begin
						case (wv[2:0])
							clkpwr_pkg::MODE_IDLE: pm_state_ff <= clkpwr_pkg::st_idle;
							clkpwr_pkg::MODE_SLEEP: pm_state_ff <= clkpwr_pkg::st_sleep;
							clkpwr_pkg::MODE_PDOWN: pm_state_ff <= clkpwr_pkg::st_pdown;
							clkpwr_pkg::MODE_DPDOWN: pm_state_ff <= clkpwr_pkg::st_dpdown;
							default: pm_state_ff <= clkpwr_pkg::st_run;
						endcase
					end
				end
				clkpwr_pkg::st_idle: begin
					if (wake_evt) begin
						pm_state_ff <= clkpwr_pkg::st_run;
					end
				end
				clkpwr_pkg::st_sleep: begin
					if (wake_evt) begin
						pm_state_ff <= clkpwr_pkg::st_wake;
						wake_cnt_ff <= 13'h0000;
						wake_lim_ff <= (act_src_ff == clkpwr_pkg::SRC_MAIN) ?
							clkpwr_pkg::WAKE_MAIN_TICKS : clkpwr_pkg::WAKE_RC_TICKS;
					end
				end
				clkpwr_pkg::st_pdown, clkpwr_pkg::st_dpdown: begin
					if (wake_evt) begin
						pm_state_ff <= clkpwr_pkg::st_wake;
						wake_cnt_ff <= 13'h0000;
						wake_lim_ff <= clkpwr_pkg::WAKE_RC_TICKS;
					end
				end
				clkpwr_pkg::st_wake: begin
					// Execution held off until the source has run the full count
					if (ref_tick) begin
						wake_cnt_ff <= wake_cnt_ff + 13'h0001;
						if (wake_cnt_ff == wake_lim_ff - 13'h0001) begin
							pm_state_ff <= clkpwr_pkg::st_run;
						end
					end
				end
				default: pm_state_ff <= clkpwr_pkg::st_run;
			endcase
		end
	end

	// Flash start-up timer in RC cycles; also runs from reset
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flash_cnt_ff <= 9'h000;
			flash_rdy_ff <= 1'b0;
		end else if (ce_in) begin
			if (wake_evt && (pm_state_ff == clkpwr_pkg::st_pdown ||
					pm_state_ff == clkpwr_pkg::st_dpdown)) begin
				flash_cnt_ff <= 9'h000;
				flash_rdy_ff <= 1'b0;
			end else if (!flash_rdy_ff && rc_tick) begin
				flash_cnt_ff <= flash_cnt_ff + 9'h001;
				flash_rdy_ff <= (flash_cnt_ff == clkpwr_pkg::FLASH_WAKE_TICKS - 9'h001);
			end
		end
	end

	// Crystal stability: software polls this before switching over
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			osc_cnt_ff <= 13'h0000;
			osc_stable_ff <= 1'b0;
		end else if (ce_in) begin
			if (!osc_en_ff || pm_state_ff == clkpwr_pkg::st_sleep) begin
				osc_cnt_ff <= 13'h0000;
				osc_stable_ff <= 1'b0;
			end else if (!osc_stable_ff && main_tick) begin
				osc_cnt_ff <= osc_cnt_ff + 13'h0001;
				osc_stable_ff <= (osc_cnt_ff == clkpwr_pkg::OSC_STABLE_TICKS - 13'h0001);
			end
		end
	end

	// ****************************************************************
	// Clock tree: source mux, PLL bypass, dividers, gates
	// ****************************************************************
	logic div_in_tick, cpu_tick, clk_live, cpu_en_ff, usb_en_ff, wd_en_ff;
	logic [7:0] cpu_cnt_ff;
	logic [3:0] usb_cnt_ff;

	assign clk_live = (pm_state_ff == clkpwr_pkg::st_run) || (pm_state_ff == clkpwr_pkg::st_idle);
	assign ref_tick = (act_src_ff == clkpwr_pkg::SRC_MAIN) ? main_tick :
		(act_src_ff == clkpwr_pkg::SRC_RTC) ? rtc_tick : rc_tick;
	assign div_in_tick = pll_conn_act_ff ? cco_tick : ref_tick;
	assign cpu_tick = div_in_tick && (cpu_cnt_ff >= cpu_div_ff);

	// Switching waits for the end of a whole CPU period, so no short pulse escapes;
	// with clocks stopped it takes effect at once. A dead old source stalls the switch.
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			act_src_ff <= clkpwr_pkg::SRC_RC;
			pll_conn_act_ff <= 1'b0;
			cpu_cnt_ff <= 8'h00;
		end else if (ce_in) begin
			if (cpu_tick || !clk_live) begin
				act_src_ff <= src_sel_ff;
				pll_conn_act_ff <= pll_en_ff & pll_conn_ff;
			end
			if (cpu_tick || !clk_live) begin
				cpu_cnt_ff <= 8'h00;
			end else if (div_in_tick) begin
				cpu_cnt_ff <= cpu_cnt_ff + 8'h01;
			end
		end
	end

	// USB clock divided from the PLL output only
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			usb_cnt_ff <= 4'h0;
			usb_en_ff <= 1'b0;
			cpu_en_ff <= 1'b0;
			wd_en_ff <= 1'b0;
		end else if (ce_in) begin
			if (!pll_en_ff || !clk_live) begin
				usb_cnt_ff <= 4'h0;
			end else if (cco_tick) begin
				usb_cnt_ff <= (usb_cnt_ff >= usb_div_ff) ? 4'h0 : usb_cnt_ff + 4'h1;
			end
			usb_en_ff <= pll_en_ff && clk_live && cco_tick && (usb_cnt_ff >= usb_div_ff);
			cpu_en_ff <= cpu_tick && (pm_state_ff == clkpwr_pkg::st_run);
			case (wd_sel_ff)
				clkpwr_pkg::WDSRC_RC: wd_en_ff <= rc_tick;
				clkpwr_pkg::WDSRC_RTC: wd_en_ff <= rtc_tick;
				default: wd_en_ff <= cpu_tick && clk_live;
			endcase
		end
	end

	// Per-peripheral divider and gate; a gated peripheral sees no pulses
	logic [NP-1:0] pclk_ff;
	generate
		for (genvar i = 0; i < NP; i++) begin : g_pclk
			logic [2:0] pcnt_ff;
			always_ff @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					pcnt_ff <= 3'h0;
					pclk_ff[i] <= 1'b0;
				end else if (ce_in) begin
					if (cpu_tick && clk_live) begin
						pcnt_ff <= pcnt_ff + 3'h1;
					end
					pclk_ff[i] <= cpu_tick && clk_live && pconp_ff[i] &&
						((pcnt_ff & div_mask(pclksel_ff[2*i +: 2])) == 3'h0);
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign cpu_core_clock_en_out = cpu_en_ff;
	assign usb_clk_en_out = usb_en_ff;
	assign pclk_en_out = pclk_ff;
	assign watchdog_tick_clock_en_out = wd_en_ff;
	assign pll_cfg_out = pll_cfg_ff;
	assign pll_enable_out = pll_en_ff | pll_conn_act_ff; // Kept running until unhooked
	assign main_osc_en_out = osc_en_ff && (pm_state_ff != clkpwr_pkg::st_sleep);
	assign rc_osc_en_out = (pm_state_ff != clkpwr_pkg::st_pdown) &&
		(pm_state_ff != clkpwr_pkg::st_dpdown);
	assign flash_pwr_out = rc_osc_en_out;
	assign flash_ready_out = flash_rdy_ff;
	assign cpu_run_out = (pm_state_ff == clkpwr_pkg::st_run);

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);

	sleep_clears_pll_a: assert property (
		$rose(pm_state_ff == clkpwr_pkg::st_sleep) && ce_in |->
		!pll_conn_ff && cpu_div_ff == 8'h00 && usb_div_ff == 4'h0)
		else $error("sleep entry left PLL or dividers set");
	pdown_pll_off_a: assert property (
		(pm_state_ff == clkpwr_pkg::st_pdown)[*3] |-> !pll_enable_out)
		else $error("PLL still enabled in power-down");
	pll_sw_enable_a: assert property (
		$rose(pll_en_ff) |-> $past(wr && wb_adr_in == clkpwr_pkg::OFS_PLL_CTRL))
		else $error("PLL enabled without a software write");
	pll_connect_a: assert property (
		$rose(pll_conn_act_ff) |-> $past(pll_en_ff && pll_conn_ff))
		else $error("PLL connected while not enabled and requested");
	wake_count_a: assert property (
		$past(pm_state_ff) == clkpwr_pkg::st_wake && pm_state_ff == clkpwr_pkg::st_run |->
		$past(wake_cnt_ff) == $past(wake_lim_ff) - 13'h0001)
		else $error("wake ended before the cycle count");
	flash_wake_a: assert property (
		$rose(flash_ready_out) |->
		$past(flash_cnt_ff) == clkpwr_pkg::FLASH_WAKE_TICKS - 9'h001)
		else $error("flash released at wrong count");
	pd_wake_rc_a: assert property (
		pm_state_ff == clkpwr_pkg::st_wake && $past(pm_state_ff) == clkpwr_pkg::st_pdown |->
		src_sel_ff == clkpwr_pkg::SRC_RC)
		else $error("power-down wake not on RC source");
	pclk_gate_a: assert property (
		pclk_en_out[0] |-> $past(pconp_ff[0] && clk_live))
		else $error("gated peripheral clock pulsed");
	cpu_clk_src_a: assert property (
		cpu_core_clock_en_out |-> $past(div_in_tick) ##0
		$past(pm_state_ff) == clkpwr_pkg::st_run)
		else $error("CPU clock pulse without source tick");
endmodule
`default_nettype wire

// [clock_source_pll_control_tb.sv]
// Self-checking bench for the clock source, PLL and power control block
`timescale 1ns/1ps
`default_nettype none
module clock_source_pll_control_tb;
	// ****************************************************************
	// Clock, oscillators and design
	// ****************************************************************
	logic mclk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, lock = 1'b0, wake = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat;
	logic ack, cpu_en, usb_en, wd_en, pll_en, mosc_en, rc_en, fpwr, frdy, run;
	logic [7:0] pclk;
	clkpwr_pkg::pll_cfg_t cfg_o;
	logic [3:0] cnt = 4'h0;
	logic rc = 1'b0, mo = 1'b0, rt = 1'b0;
	int num_errors = 0, checks_done = 0;
	// 200 MHz system clock
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// Slow oscillators; RC and crystal stand still while the block powers them off
	always @(posedge mclk) begin
		cnt <= cnt + 4'h1;
		if (rc_en === 1'b1) rc <= cnt[1];
		if (mosc_en === 1'b1) mo <= cnt[1];
		rt <= cnt[3];
	end
	clock_source_pll_control uut (.mclk_in(mclk), .arst_n_in(arst_n), .ce_in(1'b1),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
		.wb_dat_in(wdat), .wb_ack_out(ack), .wb_dat_out(rdat), .rc_osc_in(rc),
		.main_osc_in(mo), .rtc_osc_in(rt), .current_controlled_osc_in(cnt[1]),
		.pll_lock_in(lock), .wake_in(wake), .cpu_core_clock_en_out(cpu_en),
		.usb_clk_en_out(usb_en), .pclk_en_out(pclk), .watchdog_tick_clock_en_out(wd_en),
		.pll_cfg_out(cfg_o), .pll_enable_out(pll_en), .main_osc_en_out(mosc_en),
		.rc_osc_en_out(rc_en), .flash_pwr_out(fpwr), .flash_ready_out(frdy), .cpu_run_out(run));
	// ****************************************************************
	// Bench tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic single cycle: request held until ack is sampled, then released for a cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge mclk);
		while (ack !== 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) chk({31'h0, ack}, 32'h1);
		@(posedge mclk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	// Raise the wake request and count cycles until execution resumes
	task automatic wake_up(output int n);
		n = 0;
		wake <= 1'b1;
		while (run !== 1'b1 && n < 20000) begin
			@(posedge mclk);
			n++;
		end
		wake <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog: the whole sequence needs well under 60k cycles
	initial begin
		#300000;
		num_errors++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		logic [31:0] rv, v, acc;
		int n, m, k, nu, nw;
		void'($urandom(60555));
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		chk({29'h0, run, pll_en, rc_en}, 32'h5);
		chk(32'(cfg_o), 32'h0);
		rdchk(clkpwr_pkg::OFS_CLK_SRC, 32'h0);
		rdchk(clkpwr_pkg::OFS_PCLK_GATE, 32'hff);
		rdchk(8'hfc, 32'h0);
		// Crystal enabled and given its 4096 ticks before anything selects it
		wb(1'b1, clkpwr_pkg::OFS_OSC_CTL, 32'h1, rv);
		repeat (16000) @(posedge mclk);
		rdchk(clkpwr_pkg::OFS_OSC_CTL, 32'h1);
		repeat (800) @(posedge mclk);
		rdchk(clkpwr_pkg::OFS_OSC_CTL, 32'h3);
		chk({31'h0, mosc_en}, 32'h1);
		for (m = 0; m < 4; m++) begin
			wb(1'b1, clkpwr_pkg::OFS_CLK_SRC, 32'(m), rv);
			rdchk(clkpwr_pkg::OFS_CLK_SRC, (m == 3) ? 32'h2 : 32'(m));
		end
		wb(1'b1, clkpwr_pkg::OFS_CLK_SRC, 32'h0, rv);
		// Pulse rate of the CPU clock against RC ticks, one tick per 4 cycles
		v = $urandom_range(7);
		wb(1'b1, clkpwr_pkg::OFS_CPU_DIV, v, rv);
		repeat (100) @(posedge mclk);
		n = 0;
		repeat (80 * (v + 1)) begin
			@(posedge mclk);
			if (cpu_en === 1'b1) n++;
		end
		chk((n >= 19 && n <= 21) ? 32'd20 : 32'(n), 32'd20);
		wb(1'b1, clkpwr_pkg::OFS_CPU_DIV, 32'h0, rv);
		// Gated peripherals stay silent whatever their divider
		wb(1'b1, clkpwr_pkg::OFS_PCLK_SEL, $urandom, rv);
		v = $urandom_range(255);
		wb(1'b1, clkpwr_pkg::OFS_PCLK_GATE, v, rv);
		acc = 32'h0;
		repeat (300) begin
			@(posedge mclk);
			acc |= {24'h0, pclk};
		end
		chk(acc, v);
		// Random N and M that keep the oscillator in band on the 4 MHz source
		n = $urandom_range(239, 1);
		m = n * $urandom_range(137, 69);
		v = {9'h0, 15'(m - 1), 8'(n - 1)};
		wb(1'b1, clkpwr_pkg::OFS_PLL_CFG, v, rv);
		chk(32'(cfg_o), v);
		chk({31'h0, pll_en}, 32'h0);
		wb(1'b1, clkpwr_pkg::OFS_PLL_CTRL, 32'h1, rv);
		chk({31'h0, pll_en}, 32'h1);
		lock <= 1'b1;
		repeat (8) @(posedge mclk);
		rdchk(clkpwr_pkg::OFS_PLL_STAT, 32'h5);
		wb(1'b1, clkpwr_pkg::OFS_PLL_CTRL, 32'h3, rv);
		repeat (40) @(posedge mclk);
		rdchk(clkpwr_pkg::OFS_PLL_STAT, 32'h7);
		wb(1'b1, clkpwr_pkg::OFS_CPU_DIV, 32'h3, rv);
		wb(1'b1, clkpwr_pkg::OFS_USB_DIV, 32'h2, rv);
		// Pulse rates: CPU every 4 and USB every 3 PLL ticks, watchdog every RC tick
		repeat (40) @(posedge mclk);
		n = 0;
		nu = 0;
		nw = 0;
		repeat (240) begin
			@(posedge mclk);
			if (cpu_en === 1'b1) n++;
			if (usb_en === 1'b1) nu++;
			if (wd_en === 1'b1) nw++;
		end
		chk((n >= 14 && n <= 16) ? 32'd15 : 32'(n), 32'd15);
		chk((nu >= 19 && nu <= 21) ? 32'd20 : 32'(nu), 32'd20);
		chk((nw >= 59 && nw <= 61) ? 32'd60 : 32'(nw), 32'd60);
		// Every power mode, each left by a wake event; Sleep once on the crystal, once on RC
		for (k = 0; k < 5; k++) begin
			m = (k == 0) ? 1 : (k < 3) ? 2 : k;
			if (k == 1) wb(1'b1, clkpwr_pkg::OFS_CLK_SRC, 32'h1, rv);
			if (k == 2) wb(1'b1, clkpwr_pkg::OFS_CLK_SRC, 32'h0, rv);
			if (m == 3) wb(1'b1, clkpwr_pkg::OFS_CLK_SRC, 32'h2, rv);
			wb(1'b1, clkpwr_pkg::OFS_PWR_MODE, 32'(m), rv);
			repeat (2) @(posedge mclk);
			rdchk(clkpwr_pkg::OFS_PWR_MODE, 32'(m));
			chk({31'h0, run}, 32'h0);
			if (m == 2) begin
				chk({31'h0, pll_en}, 32'h0);
				rdchk(clkpwr_pkg::OFS_CPU_DIV, 32'h0);
				rdchk(clkpwr_pkg::OFS_USB_DIV, 32'h0);
			end
			if (m > 2) chk({30'h0, fpwr, pll_en}, 32'h0);
			wake_up(n);
			chk({31'h0, run}, 32'h1);
			// Crystal-sourced Sleep waits the long count, every other Sleep or power-down wake the short one
			v = (k == 1) ? 32'd16380 : 32'd12;
			if (m > 1) chk(32'(n >= v && n <= v + 48), 32'h1);
			if (m > 2) begin
				chk({30'h0, rc_en, frdy}, 32'h2);
				n = 0;
				while (frdy !== 1'b1 && n < 2500) begin
					@(posedge mclk);
					n++;
				end
				chk(32'(n >= 1400 && n <= 1700), 32'h1);
				rdchk(clkpwr_pkg::OFS_CLK_SRC, 32'h0);
			end
			if (m == 4) rdchk(clkpwr_pkg::OFS_PLL_CFG, 32'h0);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
